// ---- fps_params.svh ----
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// ****************************************
// command codes and unlock pattern
// ****************************************
`define FPS_UNLOCK1_ADDR    19'h05555
`define FPS_UNLOCK1_DATA    8'haa
`define FPS_UNLOCK2_ADDR    19'h02aaa
`define FPS_UNLOCK2_DATA    8'h55
`define FPS_PROGRAM_DATA    8'ha0
`define FPS_PAUSE_DATA      8'hb0
`define FPS_CONTINUE_DATA   8'h30
`define FPS_RESET_DATA      8'hf0

// ****************************************
// status bit positions
// ****************************************
`define FPS_POLL_BIT        7
`define FPS_TOGGLE_BIT      6
`define FPS_FAIL_BIT        5

// ****************************************
// timing
// ****************************************
`define FPS_CLK_NS          50
`define FPS_PHASE_NS        50
`define FPS_PHASE_CYC       ((`FPS_PHASE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_PAUSE_MAX_NS    15000
`define FPS_PAUSE_CYC       (`FPS_PAUSE_MAX_NS / `FPS_CLK_NS)
`define FPS_PROG_MIN_NS     10000
`define FPS_PROG_CYC        (`FPS_PROG_MIN_NS / `FPS_CLK_NS)
`define FPS_POWERUP_US      50
`define FPS_POWERUP_CYC     ((`FPS_POWERUP_US * 1000) / `FPS_CLK_NS)

`endif

// ---- fps_pkg.sv ----
package fps_pkg;
	typedef enum logic [1:0] {
		FPS_OP_PROGRAM,
		FPS_OP_PAUSE,
		FPS_OP_CONTINUE,
		FPS_OP_RESET
	} fps_op_t;

	typedef enum {
		FPS_ST_POWERUP,
		FPS_ST_IDLE,
		FPS_ST_SETUP,
		FPS_ST_STROBE,
		FPS_ST_RECOVER,
		FPS_ST_READ,
		FPS_ST_SAMPLE,
		FPS_ST_DECIDE,
		FPS_ST_DONE
	} fps_state_t;
endpackage

// ---- fps_host.sv ----
`timescale 1ns/1ns
`include "fps_params.svh"
// Behaviour
// - program is two unlock writes, program command, then address and data
// - pause is one write of its command, any address, no unlock
// - host polls toggle bit outside blocks under erase
// - continue is one write of its command, any address, no unlock
// - host holds chip select or write strobe high during power-up
// - failure bit set on program timeout; host then raises fail and returns to idle without issuing reset
module fps_host (
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            cmd_valid,
	input  wire fps_pkg::fps_op_t cmd_op,
	input  wire logic [18:0]     cmd_addr,
	input  wire logic [7:0]      cmd_data,
	output logic                 cmd_ready,
	output logic                 done,
	output logic                 fail,
	output logic                 chip_en_n,
	output logic                 out_en_n,
	output logic                 wr_en_n,
	output logic [18:0]          addr,
	output logic [7:0]           dq_o,
	output logic                 dq_oe,
	input  wire logic [7:0]      dq_i
);
	// ****************************************
	// state
	// ****************************************
	fps_pkg::fps_state_t st_r, st_nxt;
	fps_pkg::fps_op_t    op_r, op_nxt;
	logic [15:0]         cnt_r, cnt_nxt;
	logic [15:0]         wait_r, wait_nxt;
	logic [1:0]          step_r, step_nxt;
	logic [18:0]         taddr_r, taddr_nxt;
	logic [7:0]          tdata_r, tdata_nxt;
	logic [7:0]          prev_r, prev_nxt;
	logic                first_r, first_nxt;
	logic                ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt;
	logic [18:0]         a_r, a_nxt;
	logic [7:0]          d_r, d_nxt;
	logic                doe_r, doe_nxt;
	logic                rdy_r, rdy_nxt, dn_r, dn_nxt, fl_r, fl_nxt;
	logic [1:0]          last_step;
	logic [18:0]         w_a;
	logic [7:0]          w_d;
	logic                tog_r, tog_nxt;

	// ****************************************
	// write cycle contents per step
	// ****************************************
	always_comb begin
		last_step = 2'h0;
		if (op_r == fps_pkg::FPS_OP_PROGRAM) begin
			last_step = 2'h3;
		end
		w_a = taddr_nxt;
		w_d = tdata_nxt;
		if (op_nxt == fps_pkg::FPS_OP_PROGRAM) begin
			case (step_nxt)
				2'h0: begin
					w_a = `FPS_UNLOCK1_ADDR;
					w_d = `FPS_UNLOCK1_DATA;
				end
				2'h1: begin
					w_a = `FPS_UNLOCK2_ADDR;
					w_d = `FPS_UNLOCK2_DATA;
				end
				2'h2: begin
					w_a = `FPS_UNLOCK1_ADDR;
					w_d = `FPS_PROGRAM_DATA;
				end
				default: begin
					w_a = taddr_nxt;
					w_d = tdata_nxt;
				end
			endcase
		end else begin
			case (op_nxt)
				fps_pkg::FPS_OP_PAUSE: w_d = `FPS_PAUSE_DATA;
				fps_pkg::FPS_OP_CONTINUE: w_d = `FPS_CONTINUE_DATA;
				default: w_d = `FPS_RESET_DATA;
			endcase
		end
		// address and data settle a cycle before the strobes fall
		a_nxt = a_r;
		d_nxt = d_r;
		if (st_nxt == fps_pkg::FPS_ST_SETUP) begin
			a_nxt = w_a;
			d_nxt = w_d;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		cnt_nxt = cnt_r;
		wait_nxt = wait_r;
		step_nxt = step_r;
		taddr_nxt = taddr_r;
		tdata_nxt = tdata_r;
		prev_nxt = prev_r;
		first_nxt = first_r;
		ce_nxt = ce_r;
		oe_nxt = oe_r;
		we_nxt = we_r;
		doe_nxt = doe_r;
		rdy_nxt = 1'b0;
		dn_nxt = 1'b0;
		fl_nxt = fl_r;
		case (st_r)
			fps_pkg::FPS_ST_POWERUP: begin
				// strobes held high through power-up
				if (cnt_r == 16'(`FPS_POWERUP_CYC)) begin
					st_nxt = fps_pkg::FPS_ST_IDLE;
					rdy_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			fps_pkg::FPS_ST_IDLE: begin
				rdy_nxt = 1'b1;
				if (cmd_valid && rdy_r) begin
					rdy_nxt = 1'b0;
					op_nxt = cmd_op;
					taddr_nxt = cmd_addr;
					tdata_nxt = cmd_data;
					step_nxt = 2'h0;
					fl_nxt = 1'b0;
					st_nxt = fps_pkg::FPS_ST_SETUP;
				end
			end
			fps_pkg::FPS_ST_SETUP: begin
				ce_nxt = 1'b0;
				we_nxt = 1'b0; // address latched on this fall
				doe_nxt = 1'b1;
				cnt_nxt = 16'h0000;
				st_nxt = fps_pkg::FPS_ST_STROBE;
			end
			fps_pkg::FPS_ST_STROBE: begin
				if (cnt_r == 16'(`FPS_PHASE_CYC)) begin
					we_nxt = 1'b1; // data latched on this rise
					ce_nxt = 1'b1;
					cnt_nxt = 16'h0000;
					st_nxt = fps_pkg::FPS_ST_RECOVER;
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			fps_pkg::FPS_ST_RECOVER: begin
				doe_nxt = 1'b0;
				if (cnt_r == 16'(`FPS_PHASE_CYC)) begin
					cnt_nxt = 16'h0000;
					if (step_r != last_step) begin
						step_nxt = step_r + 2'h1;
						st_nxt = fps_pkg::FPS_ST_SETUP;
					end else if (op_r == fps_pkg::FPS_OP_PROGRAM
					             || op_r == fps_pkg::FPS_OP_PAUSE) begin
						first_nxt = 1'b1;
						wait_nxt = 16'h0000;
						st_nxt = fps_pkg::FPS_ST_READ;
					end else begin
						st_nxt = fps_pkg::FPS_ST_DONE;
					end
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			fps_pkg::FPS_ST_READ: begin
				ce_nxt = 1'b0;
				oe_nxt = 1'b0;
				cnt_nxt = 16'h0000;
				wait_nxt = wait_r + 16'h0001;
				st_nxt = fps_pkg::FPS_ST_SAMPLE;
			end
			fps_pkg::FPS_ST_SAMPLE: begin
				wait_nxt = wait_r + 16'h0001;
				if (cnt_r == 16'(`FPS_PHASE_CYC)) begin
					ce_nxt = 1'b1;
					oe_nxt = 1'b1;
					prev_nxt = dq_i;
					st_nxt = fps_pkg::FPS_ST_DECIDE;
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			fps_pkg::FPS_ST_DECIDE: begin
				wait_nxt = wait_r + 16'h0001;
				first_nxt = 1'b0;
				st_nxt = fps_pkg::FPS_ST_READ;
				if (op_r == fps_pkg::FPS_OP_PROGRAM) begin
					// status polled at target
					if (prev_r[`FPS_POLL_BIT] == tdata_r[`FPS_POLL_BIT]) begin
						st_nxt = fps_pkg::FPS_ST_DONE;
						fl_nxt = (prev_r != tdata_r);
					end else if (prev_r[`FPS_FAIL_BIT]) begin
						st_nxt = fps_pkg::FPS_ST_DONE;
						fl_nxt = 1'b1;
					end
				end else if (!first_r) begin
					// toggle compared between two reads
					if (prev_r[`FPS_TOGGLE_BIT] == tog_r) begin
						st_nxt = fps_pkg::FPS_ST_DONE;
					end else if (wait_r >= 16'(`FPS_PAUSE_CYC)) begin
						st_nxt = fps_pkg::FPS_ST_DONE;
						fl_nxt = 1'b1;
					end
				end
				doe_nxt = 1'b0;
			end
			fps_pkg::FPS_ST_DONE: begin
				dn_nxt = 1'b1;
				rdy_nxt = 1'b1;
				st_nxt = fps_pkg::FPS_ST_IDLE;
			end
			default: st_nxt = fps_pkg::FPS_ST_IDLE;
		endcase
	end

	// toggle bit of the previous status read
	always_comb begin
		tog_nxt = tog_r;
		if (st_r == fps_pkg::FPS_ST_DECIDE) begin
			tog_nxt = prev_r[`FPS_TOGGLE_BIT];
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= fps_pkg::FPS_ST_POWERUP;
			op_r <= fps_pkg::FPS_OP_RESET;
			cnt_r <= 16'h0000;
			wait_r <= 16'h0000;
			step_r <= 2'h0;
			taddr_r <= 19'h00000;
			tdata_r <= 8'h00;
			prev_r <= 8'h00;
			first_r <= 1'b0;
			tog_r <= 1'b0;
			ce_r <= 1'b1;
			oe_r <= 1'b1;
			we_r <= 1'b1;
			a_r <= 19'h00000;
			d_r <= 8'h00;
			doe_r <= 1'b0;
			rdy_r <= 1'b0;
			dn_r <= 1'b0;
			fl_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			cnt_r <= cnt_nxt;
			wait_r <= wait_nxt;
			step_r <= step_nxt;
			taddr_r <= taddr_nxt;
			tdata_r <= tdata_nxt;
			prev_r <= prev_nxt;
			first_r <= first_nxt;
			tog_r <= tog_nxt;
			ce_r <= ce_nxt;
			oe_r <= oe_nxt;
			we_r <= we_nxt;
			a_r <= a_nxt;
			d_r <= d_nxt;
			doe_r <= doe_nxt;
			rdy_r <= rdy_nxt;
			dn_r <= dn_nxt;
			fl_r <= fl_nxt;
		end
	end

	assign cmd_ready = rdy_r;
	assign done      = dn_r;
	assign fail      = fl_r;
	assign chip_en_n = ce_r;
	assign out_en_n  = oe_r;
	assign wr_en_n   = we_r;
	assign addr      = a_r;
	assign dq_o      = d_r;
	assign dq_oe     = doe_r;
endmodule

// ---- fps_host_monitor.sv ----
`timescale 1ns/1ns
`include "fps_params.svh"
module fps_host_monitor (
	input wire logic		clk_sys,
	input wire logic		rst,
	input wire logic		cmd_valid,
	input wire fps_pkg::fps_op_t	cmd_op,
	input wire logic		cmd_ready,
	input wire logic		done,
	input wire logic		out_en_n,
	input wire logic		wr_en_n,
	input wire logic [18:0]		addr,
	input wire logic [7:0]		dq_o,
	input wire logic		dq_oe
);
	logic [2:0]		nwr_r;
	fps_pkg::fps_op_t	op_r;
	wire			acc = cmd_valid && cmd_ready;
	wire			wl = !wr_en_n;
	wire			prog = op_r == fps_pkg::FPS_OP_PROGRAM;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys) begin
		if (rst || acc)
			nwr_r <= 3'h0;
		else if ($rose(wr_en_n))
			nwr_r <= nwr_r + 3'h1;
		if (acc)
			op_r <= cmd_op;
	end
	property p_powerup;
		$fell(rst) |-> (wr_en_n && !dq_oe && !cmd_ready) [*8];
	endproperty
	a_powerup: assert property (p_powerup) else $error("powerup");
	property p_wr_drive; wl |-> dq_oe && out_en_n; endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("drive");
	property p_rd_free; !out_en_n |-> !dq_oe && wr_en_n; endproperty
	a_rd_free: assert property (p_rd_free) else $error("read");
	property p_hold; wl && $past(wl) |-> $stable({addr, dq_o}); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_writes; done |-> nwr_r == (prog ? 3'h4 : 3'h1); endproperty
	a_writes: assert property (p_writes) else $error("writes");
	property p_unlock;
		acc && cmd_op == fps_pkg::FPS_OP_PROGRAM |-> ##[1:4] wl &&
			{addr, dq_o} == {`FPS_UNLOCK1_ADDR, `FPS_UNLOCK1_DATA};
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock");
	property p_pause;
		acc && cmd_op == fps_pkg::FPS_OP_PAUSE |->
			##[1:4] wl && dq_o == `FPS_PAUSE_DATA;
	endproperty
	a_pause: assert property (p_pause) else $error("pause");
	property p_cont;
		acc && cmd_op == fps_pkg::FPS_OP_CONTINUE |->
			##[1:4] wl && dq_o == `FPS_CONTINUE_DATA;
	endproperty
	a_cont: assert property (p_cont) else $error("continue");
endmodule
bind fps_host fps_host_monitor u_fps_host_monitor (.clk_sys(clk_sys),
	.rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
	.cmd_ready(cmd_ready), .done(done), .out_en_n(out_en_n),
	.wr_en_n(wr_en_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe));

// ---- fps_flash_model.sv ----
`timescale 1ns/1ns
`include "fps_params.svh"
module fps_flash_model (
	input wire logic	chip_en_n,
	input wire logic	out_en_n,
	input wire logic	wr_en_n,
	input wire logic [18:0]	addr,
	input wire logic [7:0]	dq_o,
	output logic [7:0]	dq_i
);
	logic [7:0]	mem [bit [18:0]] = '{default: 8'hff};
	logic [7:0]	pd;
	logic [7:0]	rd = 8'h00;
	logic [18:0]	la;
	int		stage = 0;
	int		pause_ns = 1000;
	bit		busy, erasing, paused, tog;
	bit		timer_run;
	bit [2:0]	wipe_blk = 3'h2;
	wire		wstb = wr_en_n | chip_en_n;
	always @(negedge wstb)
		la = addr;
	always @(posedge wstb) begin
		if (paused) begin
			erasing = dq_o == 8'h30;
			paused = dq_o != 8'h30 && dq_o != 8'hf0;
		end else if (dq_o == 8'hb0 && erasing) begin
			timer_run = 1'b0;
			#(pause_ns) erasing = 1'b0;
			paused = 1'b1;
		end else if (stage == 3) begin
			pd = dq_o;
			busy = 1'b1;
			#(`FPS_PROG_MIN_NS) mem[la] = mem[la] & pd;
			busy = 1'b0;
			stage = 0;
		end else if (stage == 0)
			stage = {la, dq_o} == {`FPS_UNLOCK1_ADDR, `FPS_UNLOCK1_DATA};
		else if (stage == 1)
			stage = {la, dq_o} == {`FPS_UNLOCK2_ADDR, `FPS_UNLOCK2_DATA} ? 2 : 0;
		else
			stage = dq_o == `FPS_PROGRAM_DATA ? 3 : 0;
	end
	always @(negedge out_en_n) begin
		tog = ~tog;
		if (busy)
			rd = {~pd[7], tog, 6'h00};
		else if (erasing)
			rd = {1'b0, tog, 2'h0, !timer_run, 3'h0};
		else if (paused && addr[18:16] == wipe_blk)
			rd = {8{tog}};
		else
			rd = mem[addr];
	end
	assign dq_i = (chip_en_n || out_en_n) ? ~rd : rd;
endmodule

// ---- fps_host_tb.sv ----
`timescale 1ns/1ns
module fps_host_tb;
	logic			clk_sys = 1'b0;
	logic			rst = 1'b1;
	logic			cmd_valid = 1'b0;
	fps_pkg::fps_op_t	cmd_op = fps_pkg::FPS_OP_RESET;
	logic [18:0]		cmd_addr = 19'h00000;
	logic [7:0]		cmd_data = 8'h00;
	logic			cmd_ready, done, fail, chip_en_n, out_en_n;
	logic			wr_en_n, dq_oe;
	logic [18:0]		addr, a;
	logic [7:0]		dq_o, dq_i, d;
	logic [15:0]		rnd = 16'hbd6f;
	logic [7:0]		ref_mem [bit [18:0]] = '{default: 8'hff};
	int			err_total = 0;
	int			n_tests = 0;
	int			cyc = 0;
	always #25 clk_sys = ~clk_sys;
	fps_host u_fps_host (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .done(done), .fail(fail),
		.chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
	fps_flash_model u_fps_flash_model (.chip_en_n(chip_en_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr), .dq_o(dq_o),
		.dq_i(dq_i));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic run(input fps_pkg::fps_op_t op, input logic [7:0] dat,
		input logic exp_fail);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n++ < 1500)
			@(negedge clk_sys);
		cmd_op = op;
		cmd_addr = a;
		cmd_data = dat;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n++ < 3000)
			@(negedge clk_sys);
		check(done, 1'b1);
		check(fail, exp_fail);
		$display("op %0d end", op);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			if (!i[0])
				a = {3'h5, rnd};
			d = {1'b0, rnd[14:8]};
			run(fps_pkg::FPS_OP_PROGRAM, d, |(d & ~ref_mem[a]));
			ref_mem[a] = ref_mem[a] & d;
			check(u_fps_flash_model.mem[a], ref_mem[a]);
		end
		a = 19'h00000;
		run(fps_pkg::FPS_OP_PAUSE, 8'h00, 1'b0);
		check(u_fps_flash_model.paused, 1'b0);
		u_fps_flash_model.erasing = 1'b1;
		u_fps_flash_model.timer_run = 1'b1;
		run(fps_pkg::FPS_OP_PAUSE, 8'h00, 1'b0);
		check(u_fps_flash_model.paused, 1'b1);
		check(u_fps_flash_model.timer_run, 1'b0);
		a = 19'h7ff00;
		run(fps_pkg::FPS_OP_PROGRAM, 8'h80, 1'b1);
		check(u_fps_flash_model.mem[a], 8'hff);
		run(fps_pkg::FPS_OP_CONTINUE, 8'h00, 1'b0);
		check(u_fps_flash_model.erasing, 1'b1);
		run(fps_pkg::FPS_OP_PAUSE, 8'h00, 1'b0);
		run(fps_pkg::FPS_OP_RESET, 8'h00, 1'b0);
		check(u_fps_flash_model.erasing, 1'b0);
		u_fps_flash_model.erasing = 1'b1;
		u_fps_flash_model.pause_ns = 20000;
		run(fps_pkg::FPS_OP_PAUSE, 8'h00, 1'b1);
		end_sim();
	end
endmodule
